// File: rtl/quhb_defines.svh
`ifndef QUHB_DEFINES_SVH
`define QUHB_DEFINES_SVH

// Channel and bus widths
`define QUHB_CH_N         4
`define QUHB_INTEN_W      4

// Register offsets inside one channel
`define QUHB_INTEN_OFS    3'h1
`define QUHB_MODEM_OFS    3'h4
`define QUHB_MODEM_INT_BIT 3
`define QUHB_INTEN_RST    4'h0

// Field positions in the synchronised pin vector
`define QUHB_P_MODE       0
`define QUHB_P_RST        1
`define QUHB_P_RD         2
`define QUHB_P_WR         3
`define QUHB_P_CS         4
`define QUHB_P_CSA        8
`define QUHB_P_ADDR       10
`define QUHB_P_DATA       13
`define QUHB_P_FORCE      21
`define QUHB_SYNC_W       22
// Idle levels: 16 mode, reset off, strobes and selects high
`define QUHB_SYNC_RST     22'h0000fd

`endif

// File: rtl/quhb_pkg.sv
package quhb_pkg;

  typedef logic [7:0] quhb_data_t;
  typedef logic [2:0] quhb_addr_t;
  typedef logic [1:0] quhb_chan_t;

  // Host access sequencer
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_RD_ISSUE,
    BUS_RD_DRIVE
  } quhb_bus_state_t;

endpackage : quhb_pkg

// File: rtl/quhb_sync.sv
`timescale 1ns/1ns
`default_nettype none
module quhb_sync #(
  parameter int            W       = 1,
  parameter logic [W-1:0]  RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  // Two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_ff <= RST_VAL;
      q       <= RST_VAL;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule : quhb_sync
`default_nettype wire

// File: rtl/quhb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "quhb_defines.svh"
module quhb_top (
  // System
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // Host bus pins
  input  wire logic                 bus_mode_16,
  input  wire logic                 host_reset_pin,
  input  wire logic                 host_read_strobe_n,
  input  wire logic                 host_write_strobe_n,
  input  wire logic [3:0]           host_cs_n,
  input  wire logic [1:0]           channel_select_addr,
  input  wire quhb_pkg::quhb_addr_t host_addr,
  input  wire quhb_pkg::quhb_data_t host_data_in,
  input  wire logic                 interrupt_force_select,
  // Data bus drive
  output var  quhb_pkg::quhb_data_t host_data_out,
  output logic                      host_data_oe,
  // Interrupt pins
  output logic [3:0]                chan_int_out,
  output logic [3:0]                chan_int_oe,
  output logic                      irq_n_out,
  output logic                      irq_n_oe,
  // Channel register port
  output logic                      reg_wr_stb,
  output logic                      reg_rd_stb,
  output var  quhb_pkg::quhb_chan_t reg_chan,
  output var  quhb_pkg::quhb_addr_t reg_addr,
  output var  quhb_pkg::quhb_data_t reg_wdata,
  input  wire quhb_pkg::quhb_data_t reg_rdata,
  output logic                      uart_rst,
  // Interrupt conditions per channel
  input  wire logic [3:0]           cond_rx_err,
  input  wire logic [3:0]           cond_rx_avail,
  input  wire logic [3:0]           cond_tx_empty,
  input  wire logic [3:0]           cond_modem
);

  import quhb_pkg::*;

  logic [`QUHB_SYNC_W-1:0] pin_raw;
  logic [`QUHB_SYNC_W-1:0] pin_s;
  logic                    mode16;
  logic                    force_s;
  logic                    rd_s;
  logic                    wr_s;
  logic [3:0]              cs_s;
  quhb_chan_t              csa_s;
  quhb_addr_t              addr_s;
  quhb_data_t              data_s;
  logic                    pin_rst;
  logic                    blk_rst;
  logic                    sel_ok;
  quhb_chan_t              sel_chan;
  logic                    rd_fall;
  logic                    wr_fall;
  logic                    rw_rise;
  logic                    do_wr;
  logic                    rd_prev_ff;
  logic                    wr_prev_ff;
  quhb_bus_state_t         state_ff;
  quhb_bus_state_t         nxt_state;
  logic                    nxt_wr_stb;
  logic                    nxt_rd_stb;
  quhb_chan_t              nxt_chan;
  quhb_addr_t              nxt_addr;
  quhb_data_t              nxt_wdata;
  quhb_data_t              nxt_dout;
  logic                    nxt_doe;
  logic [3:0]              pend_vec;
  logic [3:0]              gate_vec;
  logic [3:0]              nxt_int;
  logic [3:0]              nxt_int_oe;
  logic                    nxt_irq_act;

  // Pins gathered into one vector for synchronising
  assign pin_raw = {interrupt_force_select, host_data_in, host_addr,
                    channel_select_addr, host_cs_n, host_write_strobe_n,
                    host_read_strobe_n, host_reset_pin, bus_mode_16};

  quhb_sync #(
    .W       (`QUHB_SYNC_W),
    .RST_VAL (`QUHB_SYNC_RST)
  ) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .d       (pin_raw),
    .q       (pin_s)
  );

  // Pin decode, reset polarity and channel selection
  always_comb begin
    mode16   = pin_s[`QUHB_P_MODE];
    force_s  = pin_s[`QUHB_P_FORCE];
    rd_s     = pin_s[`QUHB_P_RD];
    wr_s     = pin_s[`QUHB_P_WR];
    cs_s     = pin_s[`QUHB_P_CS +: 4];
    csa_s    = pin_s[`QUHB_P_CSA +: 2];
    addr_s   = pin_s[`QUHB_P_ADDR +: 3];
    data_s   = pin_s[`QUHB_P_DATA +: 8];
    // Reset pin polarity follows the bus style
    pin_rst  = mode16 ? pin_s[`QUHB_P_RST]
                      : ~pin_s[`QUHB_P_RST];
    blk_rst  = sys_rst | pin_rst;
    sel_ok   = 1'b0;
    sel_chan = 2'h0;
    if (mode16) begin
      // Separate select per channel, lowest index wins
      for (int i = 3; i >= 0; i--) begin
        if (!cs_s[i]) begin
          sel_ok   = 1'b1;
          sel_chan = 2'(i);
        end
      end
    end else begin
      sel_ok   = ~cs_s[0];
      sel_chan = csa_s;
    end
    // Read strobe is unused in 68 mode
    rd_fall = mode16 & rd_prev_ff & ~rd_s;
    wr_fall = wr_prev_ff & ~wr_s;
    rw_rise = ~mode16 & ~wr_prev_ff & wr_s;
    do_wr   = sel_ok & wr_fall & (state_ff != BUS_RD_ISSUE);
  end

  // Host access sequencer next state
  always_comb begin
    nxt_state  = state_ff;
    nxt_wr_stb = 1'b0;
    nxt_rd_stb = 1'b0;
    nxt_chan   = reg_chan;
    nxt_addr   = reg_addr;
    nxt_wdata  = reg_wdata;
    nxt_dout   = host_data_out;
    nxt_doe    = host_data_oe;
    unique case (state_ff)
      BUS_IDLE: begin
        if (!do_wr && sel_ok && (rd_fall || rw_rise)) begin
          nxt_rd_stb = 1'b1;
          nxt_chan   = sel_chan;
          nxt_addr   = addr_s;
          nxt_state  = BUS_RD_ISSUE;
        end
      end
      BUS_RD_ISSUE: begin
        // Bit 0 of the register becomes data bit 0
        nxt_dout  = reg_rdata;
        nxt_doe   = 1'b1;
        nxt_state = BUS_RD_DRIVE;
      end
      BUS_RD_DRIVE: begin
        // Release when the read strobe rises (16 mode), the combined strobe falls again (68 mode), or the select drops
        if (!sel_ok || (mode16 ? rd_s : wr_fall)) begin
          nxt_doe   = 1'b0;
          nxt_state = BUS_IDLE;
        end
      end
    endcase
    // Write captures the bus into the addressed register
    if (do_wr) begin
      nxt_wr_stb = 1'b1;
      nxt_chan   = sel_chan;
      nxt_addr   = addr_s;
      nxt_wdata  = data_s;
    end
  end

  // Host access sequencer registers
  always_ff @(posedge clk_sys) begin
    if (blk_rst) begin
      state_ff      <= BUS_IDLE;
      rd_prev_ff    <= 1'b1;
      wr_prev_ff    <= 1'b1;
      reg_wr_stb    <= 1'b0;
      reg_rd_stb    <= 1'b0;
      reg_chan      <= 2'h0;
      reg_addr      <= 3'h0;
      reg_wdata     <= 8'h00;
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      rd_prev_ff    <= rd_s;
      wr_prev_ff    <= wr_s;
      reg_wr_stb    <= nxt_wr_stb;
      reg_rd_stb    <= nxt_rd_stb;
      reg_chan      <= nxt_chan;
      reg_addr      <= nxt_addr;
      reg_wdata     <= nxt_wdata;
      host_data_out <= nxt_dout;
      host_data_oe  <= nxt_doe;
    end
  end

  // Per-channel enable shadows and interrupt gating
  for (genvar g = 0; g < `QUHB_CH_N; g++) begin : g_chan
    logic                     gate_en_ff;
    logic [`QUHB_INTEN_W-1:0] int_en_ff;
    logic                     nxt_gate_en;
    logic [`QUHB_INTEN_W-1:0] nxt_int_en;

    // Shadow copies of the interrupt enables
    always_comb begin
      nxt_gate_en = gate_en_ff;
      nxt_int_en  = int_en_ff;
      if (do_wr && sel_chan == 2'(g)) begin
        if (addr_s == `QUHB_MODEM_OFS) begin
          nxt_gate_en = data_s[`QUHB_MODEM_INT_BIT];
        end
        if (addr_s == `QUHB_INTEN_OFS) begin
          nxt_int_en = data_s[`QUHB_INTEN_W-1:0];
        end
      end
    end

    always_ff @(posedge clk_sys) begin
      if (blk_rst) begin
        gate_en_ff <= 1'b0;
        int_en_ff  <= `QUHB_INTEN_RST;
      end else begin
        gate_en_ff <= nxt_gate_en;
        int_en_ff  <= nxt_int_en;
      end
    end

    // Modem, line error, transmit empty, receive data
    assign pend_vec[g] = |(int_en_ff & {cond_modem[g], cond_rx_err[g],
                                        cond_tx_empty[g],
                                        cond_rx_avail[g]});
    assign gate_vec[g] = gate_en_ff;
    // Force select only counts in 16 mode
    assign nxt_int[g]    = mode16 & pend_vec[g] &
                           (gate_en_ff | force_s);
    assign nxt_int_oe[g] = mode16 &
                           (gate_en_ff | force_s);
  end

  // One wired interrupt for all channels in 68 mode
  assign nxt_irq_act = ~mode16 & (|pend_vec);

  // Interrupt pin registers and channel reset
  always_ff @(posedge clk_sys) begin
    if (blk_rst) begin
      chan_int_out <= 4'h0;
      chan_int_oe  <= 4'h0;
      irq_n_out    <= 1'b1;
      irq_n_oe     <= 1'b0;
    end else begin
      chan_int_out <= nxt_int;
      chan_int_oe  <= nxt_int_oe;
      irq_n_out    <= ~nxt_irq_act;
      irq_n_oe     <= nxt_irq_act;
    end
  end

  always_ff @(posedge clk_sys) begin
    uart_rst <= blk_rst;
  end

  // Checks of the host bus behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (blk_rst);

  sequence s_rd_start;
    state_ff == BUS_IDLE && sel_ok && !do_wr && (rd_fall || rw_rise);
  endsequence
  sequence s_rd_answer;
    reg_rd_stb && !host_data_oe ##1 host_data_oe;
  endsequence
  property p_rd_answer;
    s_rd_start |=> s_rd_answer;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read access did not drive the data bus");
  property p_data_oe;
    host_data_oe |-> state_ff == BUS_RD_DRIVE && $past(sel_ok);
  endproperty
  a_data_oe: assert property (p_data_oe)
    else $error("data bus driven outside a selected read");
  property p_wr;
    do_wr |=> reg_wr_stb && reg_wdata == $past(data_s) &&
              reg_addr == $past(addr_s);
  endproperty
  a_wr: assert property (p_wr)
    else $error("write strobe did not capture the bus");
  property p_rw68;
    !mode16 && state_ff == BUS_IDLE && sel_ok && rw_rise && !wr_fall
      |=> reg_rd_stb ##1 host_data_oe;
  endproperty
  a_rw68: assert property (p_rw68)
    else $error("rising read/write strobe did not start a read");
  property p_sel68;
    !mode16 && do_wr |=> reg_chan == $past(csa_s);
  endproperty
  a_sel68: assert property (p_sel68)
    else $error("upper address did not choose the channel");
  property p_int_gate;
    $past(mode16) |-> chan_int_out ==
      $past(pend_vec & (gate_vec | {4{force_s}}));
  endproperty
  a_int_gate: assert property (p_int_gate)
    else $error("channel interrupt not gated by enables");
  property p_int_oe;
    $past(mode16) && !$past(force_s) |-> chan_int_oe == $past(gate_vec);
  endproperty
  a_int_oe: assert property (p_int_oe)
    else $error("interrupt drive does not follow modem control");
  // Drive enables come out of reset low even while forced
  property p_force;
    $past(mode16) && $past(force_s) && !$past(blk_rst)
      |-> chan_int_oe == 4'hf;
  endproperty
  a_force: assert property (p_force)
    else $error("forced interrupt outputs not enabled");
  property p_mode68;
    !$past(mode16) |-> chan_int_oe == 4'h0 &&
      irq_n_oe == $past(|pend_vec) && irq_n_out == !irq_n_oe;
  endproperty
  a_mode68: assert property (p_mode68)
    else $error("wired interrupt does not follow pending channels");
  property p_cond;
    (cond_rx_err | cond_rx_avail | cond_tx_empty | cond_modem) == 4'h0
      |-> pend_vec == 4'h0;
  endproperty
  a_cond: assert property (p_cond)
    else $error("interrupt pending with no condition present");
  property p_pin_rst;
    disable iff (sys_rst)
    pin_rst |=> uart_rst && !host_data_oe && chan_int_oe == 4'h0;
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("reset pin did not reset the block");

endmodule : quhb_top
`default_nettype wire

// File: bench/quhb_regs_model.sv
`timescale 1ns/1ns
`default_nettype none
// Channel register file standing behind the host port
module quhb_regs_model (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // Register port from the host block
  input  wire logic                 reg_wr_stb,
  input  wire quhb_pkg::quhb_chan_t reg_chan,
  input  wire quhb_pkg::quhb_addr_t reg_addr,
  input  wire quhb_pkg::quhb_data_t reg_wdata,
  output var  quhb_pkg::quhb_data_t reg_rdata
);
  import quhb_pkg::*;

  quhb_data_t mem_ff [32];

  // Store each written byte under channel and offset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) begin
        mem_ff[i] <= 8'h00;
      end
    end else if (reg_wr_stb) begin
      mem_ff[{reg_chan, reg_addr}] <= reg_wdata;
    end
  end

  // Read path answers at once for the selected place
  assign reg_rdata = mem_ff[{reg_chan, reg_addr}];
endmodule : quhb_regs_model
`default_nettype wire

// File: bench/quad_uart_host_bus_and_irq_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "quhb_defines.svh"
// Compare a design value with its expectation
`define CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
  end \
end
module quad_uart_host_bus_and_irq_tb;
  import quhb_pkg::*;

  logic       clk_sys, sys_rst, bus_mode_16, host_reset_pin;
  logic       host_read_strobe_n, host_write_strobe_n, force_sel;
  logic [3:0] host_cs_n, int_out, int_oe, c_err, c_avail, c_empty, c_mod;
  logic [1:0] channel_select_addr;
  logic       data_oe, irq_n_out, irq_n_oe, wr_stb, rd_stb, uart_rst;
  quhb_addr_t host_addr, reg_addr;
  quhb_data_t host_data_in, data_out, reg_wdata, reg_rdata;
  quhb_chan_t reg_chan;
  int         fail_count, cmp_count, cyc, rd_cnt;

  quhb_top dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_mode_16(bus_mode_16),
    .host_reset_pin(host_reset_pin),
    .host_read_strobe_n(host_read_strobe_n),
    .host_write_strobe_n(host_write_strobe_n), .host_cs_n(host_cs_n),
    .channel_select_addr(channel_select_addr), .host_addr(host_addr),
    .host_data_in(host_data_in), .interrupt_force_select(force_sel),
    .host_data_out(data_out), .host_data_oe(data_oe),
    .chan_int_out(int_out), .chan_int_oe(int_oe),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
    .reg_wr_stb(wr_stb), .reg_rd_stb(rd_stb), .reg_chan(reg_chan),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .uart_rst(uart_rst), .cond_rx_err(c_err), .cond_rx_avail(c_avail),
    .cond_tx_empty(c_empty), .cond_modem(c_mod)
  );

  quhb_regs_model regs (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr_stb(wr_stb),
    .reg_chan(reg_chan), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );

  // Clock at 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Step to just after the next rising edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // Print counts and verdict, then stop
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // Wait for the data bus drive, bounded
  task automatic wait_oe();
    for (int n = 0; n < 12 && data_oe !== 1'b1; n++) tick(1);
  endtask : wait_oe

  // Separate-strobe write; sel is the chip-select pattern
  task automatic wr16(input logic [3:0] sel, quhb_addr_t a, quhb_data_t d);
    tick(1);
    host_cs_n = sel;
    host_addr = a;
    host_data_in = d;
    host_write_strobe_n = 1'b0;
    tick(6);
    host_write_strobe_n = 1'b1;
    tick(6);
    host_data_in = ~d;
    host_cs_n = 4'hf;
  endtask : wr16

  // Separate-strobe read with expected byte
  task automatic rd16(input int ch, quhb_addr_t a, quhb_data_t e);
    tick(1);
    host_cs_n = ~(4'h1 << ch);
    host_addr = a;
    host_read_strobe_n = 1'b0;
    wait_oe();
    `CHK(data_out, e);
    host_read_strobe_n = 1'b1;
    tick(6);
    `CHK(data_oe, 1'b0);
    host_cs_n = 4'hf;
  endtask : rd16

  // Combined strobe: fall writes, rise reads back
  task automatic rw68(input logic [1:0] ch, quhb_addr_t a, quhb_data_t d);
    tick(1);
    host_cs_n = 4'he;
    channel_select_addr = ch;
    host_addr = a;
    host_data_in = d;
    host_write_strobe_n = 1'b0;
    tick(6);
    host_write_strobe_n = 1'b1;
    host_data_in = ~d;
    wait_oe();
    `CHK(data_out, d);
    host_cs_n = 4'hf;
    tick(6);
    `CHK(data_oe, 1'b0);
  endtask : rw68

  // Raise one condition class for the channels in mask m
  task automatic set_cond(input logic [3:0] m, input int cls);
    c_avail = (cls == 0) ? m : 4'h0;
    c_empty = (cls == 1) ? m : 4'h0;
    c_err = (cls == 2) ? m : 4'h0;
    c_mod = (cls == 3) ? m : 4'h0;
    tick(3);
  endtask : set_cond

  // Count register read pulses, sampled mid-cycle
  always @(negedge clk_sys) begin
    if (rd_stb === 1'b1) rd_cnt++;
  end

  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    {fail_count, cmp_count, cyc, rd_cnt} = '0;
    sys_rst = 1'b1;
    {bus_mode_16, host_read_strobe_n, host_write_strobe_n} = 3'b111;
    {host_reset_pin, force_sel, channel_select_addr} = '0;
    {host_cs_n, host_addr, host_data_in} = {4'hf, 3'h0, 8'h00};
    {c_err, c_avail, c_empty, c_mod} = '0;
    repeat (3) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    tick(4);
    `CHK({data_oe, int_oe, irq_n_oe}, 6'h00);
    // Each channel holds its own byte, bit 0 first
    for (int c = 0; c < 4; c++) begin
      wr16(~(4'h1 << c), 3'h7, 8'h01 << c);
    end
    wr16(4'hf, 3'h7, 8'hff);
    for (int c = 0; c < 4; c++) begin
      rd16(c, 3'h7, 8'h01 << c);
    end
    // Every class needs its enable bit and the modem control gate
    wr16(4'hd, `QUHB_MODEM_OFS, 8'h08);
    for (int i = 0; i < 4; i++) begin
      set_cond(4'h2, i);
      wr16(4'hd, `QUHB_INTEN_OFS, 8'h01 << i);
      tick(3);
      `CHK(int_out, 4'h2);
      wr16(4'hd, `QUHB_INTEN_OFS, ~(8'h01 << i) & 8'h0f);
      tick(3);
      `CHK(int_out, 4'h0);
    end
    wr16(4'hd, `QUHB_INTEN_OFS, 8'h0f);
    wr16(4'hd, `QUHB_MODEM_OFS, 8'h00);
    tick(3);
    `CHK(int_oe[1], 1'b0);
    force_sel = 1'b1;
    tick(5);
    `CHK({int_oe, int_out}, 8'hf2);
    // Combined-strobe style, force select left high
    bus_mode_16 = 1'b0;
    host_reset_pin = 1'b1;
    tick(6);
    `CHK(uart_rst, 1'b0);
    rw68(2'h2, 3'h7, 8'h5a);
    rw68(2'h2, `QUHB_INTEN_OFS, 8'h01);
    set_cond(4'h4, 0);
    tick(3);
    `CHK({irq_n_oe, irq_n_out, int_oe}, 6'h20);
    host_reset_pin = 1'b0;
    tick(6);
    `CHK({uart_rst, irq_n_oe}, 2'b10);
    // Back to separate strobes; high pin now resets
    bus_mode_16 = 1'b1;
    host_reset_pin = 1'b1;
    tick(6);
    `CHK(uart_rst, 1'b1);
    host_reset_pin = 1'b0;
    set_cond(4'hf, 3);
    tick(6);
    // Reset cleared the enables, so no interrupt despite conditions
    `CHK({uart_rst, int_oe, int_out}, 9'h0f0);
    `CHK(rd_cnt, 6);
    end_of_test();
  end
endmodule : quad_uart_host_bus_and_irq_tb
`default_nettype wire
